// ### stmr_pkg.sv
// package of constants and types for the standard timer module
package stmr_pkg;
  // register byte offsets
  localparam logic [4:0] STMR_OFS_CTRL0 = 5'h00;
  localparam logic [4:0] STMR_OFS_CTRL1 = 5'h04;
  localparam logic [4:0] STMR_OFS_CNTL = 5'h08;
  localparam logic [4:0] STMR_OFS_CNTH = 5'h0c;
  localparam logic [4:0] STMR_OFS_CMPAL = 5'h10;
  localparam logic [4:0] STMR_OFS_CMPAH = 5'h14;
  localparam logic [4:0] STMR_OFS_CMPP = 5'h18;
  // control 0 fields
  localparam int STMR_C0_PAUSE = 7;
  localparam int STMR_C0_CKSEL_HI = 6;
  localparam int STMR_C0_CKSEL_LO = 4;
  localparam int STMR_C0_ENABLE = 3;
  localparam logic [7:0] STMR_C0_IMPL_MASK = 8'hf8;
  // control 1 fields
  localparam int STMR_C1_MODE_HI = 7;
  localparam int STMR_C1_MODE_LO = 6;
  localparam int STMR_C1_PINF_HI = 5;
  localparam int STMR_C1_PINF_LO = 4;
  localparam int STMR_C1_OUTCTL = 3;
  localparam int STMR_C1_POLAR = 2;
  localparam int STMR_C1_SWAP = 1;
  localparam int STMR_C1_CLRSRC = 0;
  // reset values
  localparam logic [7:0] STMR_RST_CTRL0 = 8'h00;
  localparam logic [7:0] STMR_RST_CTRL1 = 8'h00;
  localparam logic [15:0] STMR_RST_CNT = 16'h0000;
  localparam logic [15:0] STMR_RST_CMPA = 16'h0000;
  localparam logic [7:0] STMR_RST_CMPP = 8'h00;
  // mode codes
  localparam logic [1:0] STMR_MODE_CMP = 2'h0;
  localparam logic [1:0] STMR_MODE_CAP = 2'h1;
  localparam logic [1:0] STMR_MODE_PWM = 2'h2;
  localparam logic [1:0] STMR_MODE_TMR = 2'h3;
  // clock select codes
  localparam logic [2:0] STMR_CK_SYS4 = 3'h0;
  localparam logic [2:0] STMR_CK_SYS = 3'h1;
  localparam logic [2:0] STMR_CK_H16 = 3'h2;
  localparam logic [2:0] STMR_CK_H64 = 3'h3;
  localparam logic [2:0] STMR_CK_SUB0 = 3'h4;
  localparam logic [2:0] STMR_CK_SUB1 = 3'h5;
  localparam logic [2:0] STMR_CK_EXTR = 3'h6;
  localparam logic [2:0] STMR_CK_EXTF = 3'h7;
  // prescaler terminal counts
  localparam logic [5:0] STMR_DIV4_MASK = 6'h03;
  localparam logic [5:0] STMR_DIV16_MASK = 6'h0f;
  localparam logic [5:0] STMR_DIV64_MASK = 6'h3f;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [4:0] addr;
  } stmr_aphase_t;

  typedef struct packed {
    logic [2:0] ext;
    logic [2:0] cap;
    logic [2:0] sub;
  } stmr_sync_t;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] cnt;
    logic [15:0] cmp_a;
    logic [7:0] cmp_p;
    logic [5:0] div;
    stmr_sync_t sy;
    stmr_aphase_t ap;
    logic [31:0] rdata;
    logic ready;
    logic lvl;
    logic pin;
    logic oe;
    logic flag_a;
    logic flag_p;
  } stmr_state_t;
endpackage

// ### stmr_top.sv
// standard timer module: ahb-lite registers, 16-bit counter, comparators, output and capture
// Function
// - 16-bit up-counter on selected clock edge
// - comparator p on top byte, a on all
// - only enable rise clears count from software
// - overflow or selected match clears, raises request
// - pause bit halts and holds count
// - clock select picks sys, prescaled, sub, pin
// - enable bit runs, holds, rise clears
// - enable rise forces initial output level
// - control 0 bits 2-0 read zero
// - mode field selects four operating modes
// - timer/counter mode leaves pin undriven
// - compare mode pin action on a match
// - pwm mode pin function selection
// - capture mode edge selection
// - requested level equal initial shows no change
// - output control sets compare initial level
// - output control sets pwm active level
// - output control ignored in timer mode
// - output control sets single pulse start level
// - polarity bit inverts output pin
// - swap bit exchanges period and duty roles
// - clear source selects a/overflow or p
`timescale 1ns/1ps
module stmr_top
  import stmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  input wire logic sub_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_oe,
  output logic compare_a_match,
  output logic compare_p_match
);

  stmr_state_t st_r;
  stmr_state_t st_nxt;

  // timer output level for a compare action code
  function automatic logic stmr_act(input logic [1:0] pf, input logic cur);
    unique case (pf)
      2'h0: stmr_act = cur;
      2'h1: stmr_act = 1'b0;
      2'h2: stmr_act = 1'b1;
      2'h3: stmr_act = ~cur;
    endcase
  endfunction

  logic [7:0] c0;
  logic [7:0] c1;
  logic [1:0] mode;
  logic [1:0] pinf;
  logic [2:0] cksel;
  logic en_rise;
  logic ck_tick;
  logic tick;
  logic [15:0] cnt_inc;
  logic ovf;
  logic hit_a;
  logic hit_p;
  logic clr;
  logic fa;
  logic fp;
  logic ext_rise;
  logic ext_fall;
  logic cap_rise;
  logic cap_fall;
  logic sub_rise;
  logic cap_go;
  logic [16:0] duty;
  logic pwm_act;
  logic [31:0] rd;

  always_comb begin
    st_nxt = st_r;
    c0 = st_r.ctrl0;
    c1 = st_r.ctrl1;
    en_rise = 1'b0;
    // ahb data phase: register writes
    if (st_r.ap.sel && st_r.ap.wr) begin
      unique case (st_r.ap.addr)
        STMR_OFS_CTRL0: c0 = hwdata[7:0] & STMR_C0_IMPL_MASK;
        STMR_OFS_CTRL1: c1 = hwdata[7:0];
        STMR_OFS_CMPAL: st_nxt.cmp_a[7:0] = hwdata[7:0];
        STMR_OFS_CMPAH: st_nxt.cmp_a[15:8] = hwdata[7:0];
        STMR_OFS_CMPP: st_nxt.cmp_p = hwdata[7:0];
        default: ;
      endcase
      en_rise = c0[STMR_C0_ENABLE] & ~st_r.ctrl0[STMR_C0_ENABLE];
    end
    mode = c1[STMR_C1_MODE_HI:STMR_C1_MODE_LO];
    pinf = c1[STMR_C1_PINF_HI:STMR_C1_PINF_LO];
    cksel = c0[STMR_C0_CKSEL_HI:STMR_C0_CKSEL_LO];

    // pin synchronisers, third stage for edge detection
    st_nxt.sy.ext = {st_r.sy.ext[1:0], external_clock_pin};
    st_nxt.sy.cap = {st_r.sy.cap[1:0], capture_input_pin};
    st_nxt.sy.sub = {st_r.sy.sub[1:0], sub_clock_pin};
    ext_rise = st_r.sy.ext[1] & ~st_r.sy.ext[2];
    ext_fall = ~st_r.sy.ext[1] & st_r.sy.ext[2];
    cap_rise = st_r.sy.cap[1] & ~st_r.sy.cap[2];
    cap_fall = ~st_r.sy.cap[1] & st_r.sy.cap[2];
    sub_rise = st_r.sy.sub[1] & ~st_r.sy.sub[2];

    // prescaler and clock source choice
    st_nxt.div = st_r.div + 6'h01;
    unique case (cksel)
      STMR_CK_SYS4: ck_tick = (st_r.div[1:0] == STMR_DIV4_MASK[1:0]);
      STMR_CK_SYS: ck_tick = 1'b1;
      STMR_CK_H16: ck_tick = (st_r.div[3:0] == STMR_DIV16_MASK[3:0]);
      STMR_CK_H64: ck_tick = (st_r.div == STMR_DIV64_MASK);
      STMR_CK_SUB0, STMR_CK_SUB1: ck_tick = sub_rise;
      STMR_CK_EXTR: ck_tick = ext_rise;
      STMR_CK_EXTF: ck_tick = ext_fall;
    endcase
    // counts only when enabled and not paused
    tick = ck_tick & c0[STMR_C0_ENABLE] & ~c0[STMR_C0_PAUSE] & ~en_rise;

    // comparators on the next count value
    cnt_inc = st_r.cnt + 16'h0001;
    ovf = tick && (cnt_inc == 16'h0000);
    hit_a = tick && (st_r.cmp_a != 16'h0000) && (cnt_inc == st_r.cmp_a);
    hit_p = tick && (st_r.cmp_p == 8'h00 ? ovf
      : (cnt_inc[15:8] == st_r.cmp_p) && (cnt_inc[7:0] == 8'h00));

    // clear source and request flags per mode
    clr = ovf;
    fa = hit_a;
    fp = hit_p;
    unique case (mode)
      STMR_MODE_PWM: clr = ovf | (c1[STMR_C1_SWAP] ? hit_a : hit_p);
      STMR_MODE_CAP: begin
        fa = 1'b0;
        fp = 1'b0;
      end
      default: begin
        clr = c1[STMR_C1_CLRSRC] ? (ovf | hit_a) : hit_p;
        fp = hit_p & ~c1[STMR_C1_CLRSRC];
      end
    endcase

    // counter
    if (en_rise) begin
      st_nxt.cnt = STMR_RST_CNT;
    end else if (clr) begin
      st_nxt.cnt = STMR_RST_CNT;
    end else if (tick) begin
      st_nxt.cnt = cnt_inc;
    end

    // capture of the count into compare a
    unique case (pinf)
      2'h0: cap_go = cap_rise;
      2'h1: cap_go = cap_fall;
      2'h2: cap_go = cap_rise | cap_fall;
      2'h3: cap_go = 1'b0;
    endcase
    cap_go = cap_go && (mode == STMR_MODE_CAP) && c0[STMR_C0_ENABLE];
    if (cap_go) begin
      st_nxt.cmp_a = st_r.cnt;
      fa = 1'b1;
    end

    // pwm duty: active while count below duty value
    duty = c1[STMR_C1_SWAP] ? {(st_r.cmp_p == 8'h00), st_r.cmp_p, 8'h00}
      : {1'b0, st_r.cmp_a};
    pwm_act = ({1'b0, st_nxt.cnt} < duty);

    // output level before polarity
    st_nxt.lvl = st_r.lvl;
    unique case (mode)
      STMR_MODE_CMP: begin
        if (en_rise) begin
          st_nxt.lvl = c1[STMR_C1_OUTCTL];
        end else if (hit_a) begin
          st_nxt.lvl = stmr_act(pinf, st_r.lvl);
        end
      end
      STMR_MODE_PWM: begin
        unique case (pinf)
          2'h0: st_nxt.lvl = ~c1[STMR_C1_OUTCTL];
          2'h1: st_nxt.lvl = c1[STMR_C1_OUTCTL];
          2'h2: st_nxt.lvl = pwm_act ? c1[STMR_C1_OUTCTL] : ~c1[STMR_C1_OUTCTL];
          2'h3: begin
            if (en_rise) begin
              st_nxt.lvl = c1[STMR_C1_OUTCTL];
            end else if (c1[STMR_C1_SWAP] ? hit_p : hit_a) begin
              // pulse ends: inactive level and timer stops
              st_nxt.lvl = ~c1[STMR_C1_OUTCTL];
              c0[STMR_C0_ENABLE] = 1'b0;
            end
          end
        endcase
      end
      default: ;
    endcase
    st_nxt.pin = st_nxt.lvl ^ c1[STMR_C1_POLAR];
    st_nxt.oe = (mode == STMR_MODE_CMP) || (mode == STMR_MODE_PWM);
    st_nxt.flag_a = fa;
    st_nxt.flag_p = fp;
    st_nxt.ctrl0 = c0;
    st_nxt.ctrl1 = c1;

    // ahb address phase and read data
    st_nxt.ready = 1'b1;
    st_nxt.ap.sel = hsel && hready && htrans[1];
    st_nxt.ap.wr = hwrite;
    st_nxt.ap.addr = haddr[4:0];
    if (haddr[31:5] != 27'h0000000 || haddr[1:0] != 2'h0) begin
      st_nxt.ap.addr = 5'h1f;
    end
    unique case (st_nxt.ap.addr)
      STMR_OFS_CTRL0: rd = {24'h000000, c0};
      STMR_OFS_CTRL1: rd = {24'h000000, c1};
      STMR_OFS_CNTL: rd = {24'h000000, st_nxt.cnt[7:0]};
      STMR_OFS_CNTH: rd = {24'h000000, st_nxt.cnt[15:8]};
      STMR_OFS_CMPAL: rd = {24'h000000, st_nxt.cmp_a[7:0]};
      STMR_OFS_CMPAH: rd = {24'h000000, st_nxt.cmp_a[15:8]};
      STMR_OFS_CMPP: rd = {24'h000000, st_nxt.cmp_p};
      default: rd = 32'h00000000;
    endcase
    st_nxt.rdata = st_r.rdata;
    if (st_nxt.ap.sel && !hwrite) begin
      st_nxt.rdata = rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.ctrl0 <= STMR_RST_CTRL0;
      st_r.ctrl1 <= STMR_RST_CTRL1;
      st_r.cnt <= STMR_RST_CNT;
      st_r.cmp_a <= STMR_RST_CMPA;
      st_r.cmp_p <= STMR_RST_CMPP;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.ready;
  assign hresp = 1'b0;
  assign timer_output_pin = st_r.pin;
  assign timer_output_pin_oe = st_r.oe;
  assign compare_a_match = st_r.flag_a;
  assign compare_p_match = st_r.flag_p;

endmodule

// ### stmr_top_assertions.sv
// concurrent checks on the timer register and pin behaviour
`timescale 1ns/1ps
module stmr_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic capture_input_pin,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe,
  input wire logic compare_a_match,
  input wire logic compare_p_match
);
  logic w0_r, w1_r, en_r;
  logic [7:0] c1_r;
  wire acc = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w0_r <= 1'b0;
      w1_r <= 1'b0;
      en_r <= 1'b0;
      c1_r <= 8'h00;
    end else begin
      w0_r <= acc && hwrite && haddr == 32'h0;
      w1_r <= acc && hwrite && haddr == 32'h4;
      if (w0_r)
        en_r <= hwdata[3];
      if (w1_r)
        c1_r <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_c0_low_zero: assert property (acc && !hwrite && haddr == 32'h0 |=> hrdata[2:0] == 3'h0)
    else $error("control 0 low bits not zero");
  a_rd_upper_zero: assert property (acc && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_oe_timer_off: assert property ((c1_r[7:6] == 2'h3) [*3] |-> !timer_output_pin_oe)
    else $error("pin driven in timer mode");
  a_oe_cmp_on: assert property ((c1_r[7:6] == 2'h0) [*3] |-> timer_output_pin_oe)
    else $error("pin not driven in compare mode");
  a_init_level: assert property (
    $rose(en_r) && c1_r[7:6] == 2'h0 |-> ##[1:2] timer_output_pin == (c1_r[3] ^ c1_r[2]))
    else $error("initial pin level wrong");
  a_pin_no_change: assert property (
    (en_r && c1_r[7:4] == 4'h0 && $stable(c1_r)) [*3] |-> $stable(timer_output_pin))
    else $error("pin moved with no-change function");
  a_p_spacing: assert property (compare_p_match |=> !compare_p_match [*8])
    else $error("p match pulses too close");
  a_cap_off_quiet: assert property ((c1_r[7:4] == 4'h7) [*4] |-> !compare_a_match)
    else $error("capture pulse while disabled");
  a_cap_edge_pulse: assert property (
    c1_r[7:4] == 4'h4 && en_r && $rose(capture_input_pin) |-> ##[2:6] compare_a_match)
    else $error("no capture pulse on rising edge");
  c_a_pulse: cover property (compare_a_match);
  c_p_pulse: cover property (compare_p_match);
  c_pin_rise: cover property ($rose(timer_output_pin));
endmodule

bind stmr_top stmr_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .capture_input_pin, .timer_output_pin, .timer_output_pin_oe,
  .compare_a_match, .compare_p_match);

// ### tb_standard_timer_module_16bit.sv
// self-checking bench of the standard timer module
`timescale 1ns/1ps
module tb_standard_timer_module_16bit
  import stmr_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, ext, cap, sub, hreadyout, hresp, pin, oe, am, pm;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors, checks_done, seed, na, n0, cyc, tp, tq;
  stmr_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_clock_pin(ext), .capture_input_pin(cap),
    .sub_clock_pin(sub), .timer_output_pin(pin), .timer_output_pin_oe(oe),
    .compare_a_match(am), .compare_p_match(pm));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (am === 1'b1)
      na <= na + 1;
    if (pm === 1'b1) begin
      tq <= tp;
      tp <= cyc;
    end
    if (cyc % 4 == 0) begin
      ext <= ~ext;
      sub <= ~sub;
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmpv(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpl(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t pin %b expected %b", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 8'h00);
    cmpv(rd, e);
    cmpl(hresp, 1'b0);
  endtask
  task automatic restart(input logic [7:0] c1);
    wr(STMR_OFS_CTRL0, 8'h10);
    wr(STMR_OFS_CTRL1, c1);
    wr(STMR_OFS_CTRL0, 8'h18);
  endtask
  function automatic int gap(input int c);
    return c == 0 ? 8 : c == 1 ? 2 : c == 2 ? 32 : c == 3 ? 128 : 16;
  endfunction
  function automatic logic lvl(input logic [3:0] k);
    case (k[1:0])
      2'h0: return k[2] ^ k[3];
      2'h1: return k[3];
      2'h2: return ~k[3];
      default: return ~k[2] ^ k[3];
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    complete_run();
  end
  initial begin
    {hresetn, hsel, hwrite, ext, cap, sub, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {num_errors, checks_done, na, cyc, tp, tq} = '0;
    seed = 63330;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdc(5'(i * 4), 32'h0);
    wr(STMR_OFS_CTRL0, 8'hff);
    rdc(STMR_OFS_CTRL0, 32'hf8);
    wr(STMR_OFS_CTRL0, 8'h00);
    wr(STMR_OFS_CNTL, 8'h5a);
    rdc(STMR_OFS_CNTL, 32'h0);
    repeat (6) begin
      v = $random(seed);
      wr(STMR_OFS_CMPAL, v[7:0]);
      wr(STMR_OFS_CMPAH, v[15:8]);
      wr(STMR_OFS_CMPP, v[23:16]);
      rdc(STMR_OFS_CMPAL, {24'h0, v[7:0]});
      rdc(STMR_OFS_CMPAH, {24'h0, v[15:8]});
      rdc(STMR_OFS_CMPP, {24'h0, v[23:16]});
    end
    $display("registers done");
    wr(STMR_OFS_CMPP, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(STMR_OFS_CTRL0, {1'b0, 3'(c), 4'h8});
      xfer(STMR_OFS_CNTL, 1'b0, 8'h00);
      v = rd;
      repeat (gap(c) - 2) @(posedge hclk);
      xfer(STMR_OFS_CNTL, 1'b0, 8'h00);
      cmpv((rd - v) & 32'hff, 32'h2);
    end
    wr(STMR_OFS_CTRL0, 8'h98);
    xfer(STMR_OFS_CNTL, 1'b0, 8'h00);
    v = rd;
    repeat (10) @(posedge hclk);
    rdc(STMR_OFS_CNTL, v);
    wr(STMR_OFS_CTRL0, 8'h10);
    rdc(STMR_OFS_CNTL, v);
    wr(STMR_OFS_CTRL0, 8'h18);
    rdc(STMR_OFS_CNTH, 32'h0);
    $display("counting done");
    wr(STMR_OFS_CMPAH, 8'h00);
    wr(STMR_OFS_CMPAL, 8'h40);
    for (int k = 0; k < 16; k++) begin
      restart({2'h0, 2'(k), k[2], k[3], 2'h0});
      repeat (4) @(posedge hclk);
      cmpl(pin, k[2] ^ k[3]);
      n0 = na;
      repeat (80) @(posedge hclk);
      cmpl(pin, lvl(4'(k)));
      cmpl(oe, 1'b1);
      cmpv(na - n0, 32'h1);
    end
    v = $random(seed);
    restart({2'h3, v[5:0]});
    repeat (4) @(posedge hclk);
    cmpl(oe, 1'b0);
    for (int k = 0; k < 8; k++) begin
      restart({2'h2, 1'b0, k[0], k[1], k[2], 2'h0});
      repeat (4) @(posedge hclk);
      cmpl(pin, k[0] ? k[1] ^ k[2] : ~k[1] ^ k[2]);
    end
    $display("output modes done");
    for (int k = 0; k < 4; k++) begin
      restart({2'h1, 2'(k), 4'h0});
      n0 = na;
      cap <= 1'b1;
      repeat (10) @(posedge hclk);
      cap <= 1'b0;
      repeat (10) @(posedge hclk);
      cmpv(na - n0, k == 2 ? 32'h2 : k == 3 ? 32'h0 : 32'h1);
    end
    wr(STMR_OFS_CMPAH, 8'h00);
    wr(STMR_OFS_CMPAL, 8'h20);
    restart(8'hb8);
    repeat (4) @(posedge hclk);
    cmpl(pin, 1'b1);
    repeat (60) @(posedge hclk);
    cmpl(pin, 1'b0);
    rdc(STMR_OFS_CTRL0, 32'h10);
    wr(STMR_OFS_CMPP, 8'h01);
    restart(8'h00);
    repeat (700) @(posedge hclk);
    cmpv(tp - tq, 32'd256);
    $display("capture and period done");
    complete_run();
  end
endmodule
